/* File: sfl_link.sv */
`timescale 1ns/1ns
`include "sfl_regs.svh"
// Notes on behaviour
// - sample input on rising clock edge, launch output on falling edge, always.
// - accept transactions with clock idling low or high at select fall.
// - output valid during low phase in compatible modes; both to 66 MHz.
// - decode 0b/e8 array read, 03 low-frequency array read, d2 page read.
// - decode d4/d6 buffer read and d1/d3 low-frequency buffer read.
// - decode 32, 35, 77, d7 and 9f register reads.
// - page size starts at 264 bytes; reconfigurable or factory set to 256.
module sfl_link
    import sfl_pkg::*;
#(
    parameter logic FACTORY_POW2 = 1'b0
) (
    // system clock and reset
    input  wire logic         mclk,
    input  wire logic         rst,
    // serial link, clocked by the host
    input  wire logic         sck,
    input  wire logic         cs_n,
    input  wire logic         si,
    input  wire logic         reset_n,
    output logic              so_o,
    output logic              so_oe,
    // device core side, mclk domain
    input  wire logic         pow2_req,
    input  wire logic [7:0]   tx_data,
    output sfl_cmd_msg_t      cmd_msg,
    output logic              cmd_valid,
    output sfl_byte_t         rx_byte,
    output logic              rx_valid,
    output logic [8:0]        page_size,
    output logic              busy
);
    // ==========================================================
    // link domain: shift in on rising sck
    // ==========================================================
    // cs_n high acts as async reset of the link logic except the received word, first-byte flag and toggle, since sck may stop
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic [7:0] rx_word_q;
    logic       rx_first_q;
    logic       have_op_q;
    logic       rx_tog_q;
    logic [7:0] tx_hold_q;

    wire        link_rst = cs_n | ~reset_n;
    wire [7:0]  shift_d  = {shift_q[6:0], si};
    wire        byte_end = (bit_cnt_q == 3'h7);

    // mode 0 and mode 3 both take the first bit on the first rising edge
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            bit_cnt_q  <= 3'h0;
            shift_q    <= 8'h00;
            have_op_q  <= 1'b0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shift_q   <= shift_d;
            if (byte_end) begin
                have_op_q  <= 1'b1;
            end
        end
    end

    // word and toggle survive cs_n: a frame cut right after a byte still delivers it
    always_ff @(posedge sck or negedge reset_n) begin
        if (!reset_n) begin
            rx_tog_q   <= 1'b0;
            rx_word_q  <= 8'h00;
            rx_first_q <= 1'b0;
        end else if (!cs_n && byte_end) begin
            rx_tog_q   <= ~rx_tog_q;
            rx_word_q  <= shift_d;
            rx_first_q <= ~have_op_q;
        end
    end

    // ==========================================================
    // link domain: launch out on falling sck
    // ==========================================================
    logic [2:0] out_cnt_q;
    logic [7:0] out_sh_q;
    logic       so_q;
    logic       oe_q;

    // first falling edge of a byte reloads from the core's byte
    wire        out_load = (out_cnt_q == 3'h0);
    wire [7:0]  out_src  = out_load ? tx_hold_q : out_sh_q;

    always_ff @(negedge sck or posedge link_rst) begin
        if (link_rst) begin
            out_cnt_q <= 3'h0;
            out_sh_q  <= 8'h00;
            so_q      <= 1'b0;
            oe_q      <= 1'b0;
        end else begin
            // launch only once the opcode is in; output valid in low phase
            if (have_op_q) begin
                so_q      <= out_src[7];
                out_sh_q  <= {out_src[6:0], 1'b0};
                out_cnt_q <= out_cnt_q + 3'h1;
                oe_q      <= 1'b1;
            end
        end
    end

    // tx_data is quasi-static over a byte; core updates it one byte ahead
    always_ff @(posedge sck or posedge link_rst) begin
        if (link_rst) begin
            tx_hold_q <= 8'h00;
        end else if (byte_end) begin
            tx_hold_q <= tx_data;
        end
    end

    // pin drivers stay combinational from link flops: an mclk copy would add skew
    assign so_o  = so_q & ~cs_n;
    assign so_oe = oe_q & ~cs_n;

    // ==========================================================
    // crossing into mclk
    // ==========================================================
    logic       tog_s;
    logic       sel_s;
    logic       rstn_s;

    sfl_sync #(.W(1)) u_sync_tog (
        .clk (mclk),
        .rst (rst),
        .d   (rx_tog_q),
        .q   (tog_s)
    );

    sfl_sync #(.W(1)) u_sync_cs (
        .clk (mclk),
        .rst (rst),
        .d   (~cs_n),
        .q   (sel_s)
    );

    sfl_sync #(.W(1)) u_sync_rst (
        .clk (mclk),
        .rst (rst),
        .d   (reset_n),
        .q   (rstn_s)
    );

    // select synced in true polarity so busy rests low straight out of reset

    // ==========================================================
    // mclk domain: opcode decode and page size
    // ==========================================================
    logic       tog_q;
    logic       pow2_q;
    logic       strap_done_q;

    wire        rx_evt = tog_s ^ tog_q;
    // word stable: it changed on the same sck edge as the toggle, which then takes several mclk cycles to cross
    wire [7:0]  op     = rx_word_q;
    wire        is_op  = rx_evt & rx_first_q;

    sfl_cmd_t   dec;
    wire        buf2   = (op == `SFL_OP_BUF2_READ) | (op == `SFL_OP_BUF2_READ_LF);

    assign dec =
        ((op == `SFL_OP_ARRAY_READ) | (op == `SFL_OP_ARRAY_READ_OLD)) ? SFL_CMD_ARRAY    :
        (op == `SFL_OP_ARRAY_READ_LF)                                  ? SFL_CMD_ARRAY_LF :
        (op == `SFL_OP_PAGE_READ)                                      ? SFL_CMD_PAGE     :
        ((op == `SFL_OP_BUF1_READ) | (op == `SFL_OP_BUF2_READ))        ? SFL_CMD_BUF      :
        ((op == `SFL_OP_BUF1_READ_LF) | (op == `SFL_OP_BUF2_READ_LF))  ? SFL_CMD_BUF_LF   :
        (op == `SFL_OP_PROT_READ)                                      ? SFL_CMD_PROT     :
        (op == `SFL_OP_LOCK_READ)                                      ? SFL_CMD_LOCK     :
        (op == `SFL_OP_SEC_READ)                                       ? SFL_CMD_SEC      :
        (op == `SFL_OP_STATUS_READ)                                    ? SFL_CMD_STATUS   :
        (op == `SFL_OP_ID_READ)                                        ? SFL_CMD_ID       :
                                                                         SFL_CMD_OTHER;

    wire        dev_rst = rst | ~rstn_s;

    always_ff @(posedge mclk) begin
        if (dev_rst) begin
            tog_q     <= 1'b0;
            cmd_valid <= 1'b0;
            rx_valid  <= 1'b0;
            cmd_msg   <= '{cmd: SFL_CMD_NONE, buf_sel: 1'b0, opcode: 8'h00};
            rx_byte   <= '{first: 1'b0, data: 8'h00};
        end else begin
            tog_q     <= tog_s;
            cmd_valid <= is_op;
            rx_valid  <= rx_evt & ~rx_first_q;
            if (is_op) begin
                cmd_msg <= '{cmd: dec, buf_sel: buf2, opcode: op};
            end
            if (rx_evt) begin
                rx_byte <= '{first: rx_first_q, data: op};
            end
        end
    end

    // page size: strap caught after reset release, software switch is one-way
    always_ff @(posedge mclk) begin
        if (rst) begin
            pow2_q       <= 1'b0;
            strap_done_q <= 1'b0;
            page_size    <= `SFL_PAGE_STD;
            busy         <= 1'b0;
        end else begin
            strap_done_q <= 1'b1;
            if (!strap_done_q) begin
                pow2_q <= FACTORY_POW2;
            end else if (pow2_req) begin
                pow2_q <= 1'b1;
            end
            page_size <= pow2_q ? `SFL_PAGE_POW2 : `SFL_PAGE_STD;
            busy      <= sel_s;
        end
    end
endmodule : sfl_link

/* File: sfl_regs.svh */
`ifndef SFL_REGS_SVH
`define SFL_REGS_SVH

// read opcodes
`define SFL_OP_ARRAY_READ      8'h0b
`define SFL_OP_ARRAY_READ_OLD  8'he8
`define SFL_OP_ARRAY_READ_LF   8'h03
`define SFL_OP_PAGE_READ       8'hd2
`define SFL_OP_BUF1_READ       8'hd4
`define SFL_OP_BUF2_READ       8'hd6
`define SFL_OP_BUF1_READ_LF    8'hd1
`define SFL_OP_BUF2_READ_LF    8'hd3
`define SFL_OP_PROT_READ       8'h32
`define SFL_OP_LOCK_READ       8'h35
`define SFL_OP_SEC_READ        8'h77
`define SFL_OP_STATUS_READ     8'hd7
`define SFL_OP_ID_READ         8'h9f

// page sizes in bytes
`define SFL_PAGE_STD           9'h108
`define SFL_PAGE_POW2          9'h100

// bits per byte on the link
`define SFL_BYTE_BITS          4'h8

`endif

/* File: sfl_pkg.sv */
package sfl_pkg;

    typedef enum logic [3:0] {
        SFL_CMD_NONE      = 4'b0000,
        SFL_CMD_ARRAY     = 4'b0001,
        SFL_CMD_ARRAY_LF  = 4'b0010,
        SFL_CMD_PAGE      = 4'b0011,
        SFL_CMD_BUF       = 4'b0100,
        SFL_CMD_BUF_LF    = 4'b0101,
        SFL_CMD_PROT      = 4'b0110,
        SFL_CMD_LOCK      = 4'b0111,
        SFL_CMD_SEC       = 4'b1000,
        SFL_CMD_STATUS    = 4'b1001,
        SFL_CMD_ID        = 4'b1010,
        SFL_CMD_OTHER     = 4'b1011
    } sfl_cmd_t;

    // a decoded command handed from the link to the core
    typedef struct packed {
        sfl_cmd_t   cmd;
        logic       buf_sel;
        logic [7:0] opcode;
    } sfl_cmd_msg_t;

    // one byte received from the link; first marks the opcode byte
    typedef struct packed {
        logic       first;
        logic [7:0] data;
    } sfl_byte_t;

endpackage : sfl_pkg

/* File: sfl_sync.sv */
`timescale 1ns/1ns
// three-stage synchroniser; a change counts once stages two and three agree
module sfl_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // signals
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    wire [W-1:0] agree = ~(s2_q ^ s3_q);
    wire [W-1:0] q_d   = (agree & s3_q) | (~agree & q);

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q    <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q    <= q_d;
        end
    end
endmodule : sfl_sync

/* File: sfl_link_monitor.sv */
`timescale 1ns/1ns
`include "sfl_regs.svh"
module sfl_link_monitor
    import sfl_pkg::*;
#(
    parameter logic FACTORY_POW2 = 1'b0
) (
    // clocks and resets
    input wire logic         mclk,
    input wire logic         rst,
    input wire logic         reset_n,
    // serial link
    input wire logic         sck,
    input wire logic         cs_n,
    input wire logic         si,
    input wire logic         so_o,
    input wire logic         so_oe,
    // core side
    input wire logic         pow2_req,
    input wire logic [7:0]   tx_data,
    input wire sfl_cmd_msg_t cmd_msg,
    input wire logic         cmd_valid,
    input wire sfl_byte_t    rx_byte,
    input wire logic         rx_valid,
    input wire logic [8:0]   page_size,
    input wire logic         busy
);
    localparam logic [8:0] PAGE0 = FACTORY_POW2 ? `SFL_PAGE_POW2 : `SFL_PAGE_STD;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ==========================================
    // checks
    a_oe_idle_off: assert property (cs_n |-> !so_oe)
        else $error("output enabled while deselected");
    a_so_hold_high: assert property (sck && $past(sck) && !cs_n && !$past(cs_n) |-> $stable(so_o))
        else $error("output moved while clock high");
    a_busy_on_sel: assert property ($fell(cs_n) |-> ##[2:8] busy)
        else $error("select not seen");
    a_cmd_single: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse too long");
    a_rx_single: assert property (rx_valid |=> !rx_valid && !cmd_valid)
        else $error("byte pulse too long");
    a_page_reset: assert property ($fell(rst) |-> ##2 page_size == PAGE0)
        else $error("wrong page size after reset");
    a_page_pow2: assert property (pow2_req |-> ##[1:4] page_size == `SFL_PAGE_POW2)
        else $error("page size not switched");
    a_dec_array: assert property (cmd_valid && (cmd_msg.opcode == `SFL_OP_ARRAY_READ
        || cmd_msg.opcode == `SFL_OP_ARRAY_READ_OLD) |-> cmd_msg.cmd == SFL_CMD_ARRAY)
        else $error("array read misdecoded");
    a_dec_buf: assert property (cmd_valid && (cmd_msg.opcode == `SFL_OP_BUF1_READ
        || cmd_msg.opcode == `SFL_OP_BUF2_READ) |-> cmd_msg.cmd == SFL_CMD_BUF)
        else $error("buffer read misdecoded");
    a_dec_id: assert property (cmd_valid && cmd_msg.opcode == `SFL_OP_ID_READ |-> cmd_msg.cmd == SFL_CMD_ID)
        else $error("id read misdecoded");
    c_other: cover property (cmd_valid && cmd_msg.cmd == SFL_CMD_OTHER);
    c_rx: cover property (rx_valid && !rx_byte.first);
    c_pow2: cover property (page_size == `SFL_PAGE_POW2);
endmodule : sfl_link_monitor

bind sfl_link sfl_link_monitor #(.FACTORY_POW2(FACTORY_POW2)) sfl_link_monitor_i (
    .mclk(mclk), .rst(rst), .reset_n(reset_n), .sck(sck), .cs_n(cs_n), .si(si),
    .so_o(so_o), .so_oe(so_oe), .pow2_req(pow2_req), .tx_data(tx_data),
    .cmd_msg(cmd_msg), .cmd_valid(cmd_valid), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .page_size(page_size), .busy(busy));

/* File: sfl_host_model.sv */
`timescale 1ns/1ns
module sfl_host_model (
    // serial link, host side
    output logic      sck,
    output logic      cs_n,
    output logic      si,
    input  wire logic so_o
);
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        si   = 1'b0;
    end
    // opcode then one data byte; cpol is the idle clock level
    task automatic xfer(input logic cpol, input logic [15:0] tx, output logic [7:0] rx);
        sck = cpol;
        #7 cs_n = 1'b0;
        si = tx[15];
        if (cpol) #32 sck = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            #32 sck = 1'b1;
            #1 si = (i > 0) ? tx[(i+15)%16] : ~si;
            #31 if (i < 8) rx[i] = so_o;
            sck = 1'b0;
        end
        #32 cs_n = 1'b1;
        si = ~si;
        #8 sck = cpol;
    endtask : xfer
    // activity while deselected, only for the ignore scenario
    task automatic noise;
        repeat (16) begin
            #32 sck = ~sck;
            si = ~si;
        end
    endtask : noise
    // rewrite bookkeeping a host keeps beside its page writes
    localparam int REWRITE_LIMIT = 10000;
    int ops_done = 0;
    int page_ptr = 0;
    // one page written, by program command or buffer write then program
    task automatic page_written(input int pages, output logic due, output int addr);
        ops_done++;
        due  = (ops_done % (REWRITE_LIMIT / pages)) == 0;
        addr = page_ptr;
        if (due) page_ptr = (page_ptr + 1) % pages;
    endtask : page_written
endmodule : sfl_host_model

/* File: sfl_link_tb.sv */
`timescale 1ns/1ns
module sfl_link_tb;
    import sfl_pkg::*;
    logic         mclk, rst, sck, cs_n, si, reset_n, so_o, so_oe;
    logic         pow2_req, cmd_valid, rx_valid, busy;
    logic [7:0]   tx_data;
    logic [8:0]   page_size;
    sfl_cmd_msg_t cmd_msg, last_cmd;
    sfl_byte_t    rx_byte, last_rx;
    int           bad_count, checks_done, n_cmd, n_rx;
    localparam logic [7:0] OPS [14] = '{8'h0b, 8'he8, 8'h03, 8'hd2, 8'hd4, 8'hd6, 8'hd1,
        8'hd3, 8'h32, 8'h35, 8'h77, 8'hd7, 8'h9f, 8'h5a};
    localparam sfl_cmd_t EXP [14] = '{SFL_CMD_ARRAY, SFL_CMD_ARRAY, SFL_CMD_ARRAY_LF, SFL_CMD_PAGE,
        SFL_CMD_BUF, SFL_CMD_BUF, SFL_CMD_BUF_LF, SFL_CMD_BUF_LF, SFL_CMD_PROT, SFL_CMD_LOCK,
        SFL_CMD_SEC, SFL_CMD_STATUS, SFL_CMD_ID, SFL_CMD_OTHER};

    sfl_link sfl_link_i (.mclk(mclk), .rst(rst), .sck(sck), .cs_n(cs_n), .si(si),
        .reset_n(reset_n), .so_o(so_o), .so_oe(so_oe), .pow2_req(pow2_req),
        .tx_data(tx_data), .cmd_msg(cmd_msg), .cmd_valid(cmd_valid), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .page_size(page_size), .busy(busy));
    sfl_host_model sfl_host_model_i (.sck(sck), .cs_n(cs_n), .si(si), .so_o(so_o));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (rst) begin
            n_cmd <= 0;
            n_rx  <= 0;
        end
        if (cmd_valid === 1'b1) begin
            last_cmd <= cmd_msg;
            n_cmd    <= n_cmd + 1;
        end
        if (rx_valid === 1'b1) begin
            last_rx <= rx_byte;
            n_rx    <= n_rx + 1;
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic t_reset;
        chk("page size", 16'h0108, page_size);
        chk("oe idle", 16'h0000, so_oe);
    endtask : t_reset
    // every read opcode, alternating idle clock level
    task automatic t_decode;
        logic [7:0] rx;
        for (int k = 0; k < 14; k++) begin
            @(negedge mclk) tx_data = 8'h5c ^ 8'(k * 17);
            sfl_host_model_i.xfer(k[0], {OPS[k], ~OPS[k]}, rx);
            repeat (10) @(negedge mclk);
            chk("cmd", EXP[k], last_cmd.cmd);
            chk("opcode", OPS[k], last_cmd.opcode);
            chk("data byte", {1'b0, ~OPS[k]}, last_rx);
            chk("so byte", tx_data, rx);
            chk("events", 16'(2 * k + 2), 16'(n_cmd + n_rx));
        end
    endtask : t_decode
    task automatic t_idle;
        int c0;
        c0 = n_cmd + n_rx;
        sfl_host_model_i.noise();
        repeat (10) @(negedge mclk);
        chk("idle events", 16'(c0), 16'(n_cmd + n_rx));
        chk("busy idle", 16'h0000, busy);
    endtask : t_idle
    task automatic t_pow2;
        @(negedge mclk) pow2_req = 1'b1;
        @(negedge mclk) pow2_req = 1'b0;
        repeat (6) @(negedge mclk);
        chk("page size", 16'h0100, page_size);
    endtask : t_pow2
    // a host rewriting a sector of 8 pages must visit each page within the op limit
    task automatic t_rewrite;
        logic due;
        int   addr, n_due, n_hit;
        n_due = 0;
        n_hit = 0;
        for (int n = 0; n < 10000; n++) begin
            sfl_host_model_i.page_written(8, due, addr);
            if (due) begin
                if (addr == n_due) n_hit++;
                n_due++;
            end
        end
        chk("rewrites", 16'h0008, 16'(n_due));
        chk("pointer order", 16'h0008, 16'(n_hit));
        chk("pointer wrap", 16'h0000, 16'(sfl_host_model_i.page_ptr));
    endtask : t_rewrite

    initial begin
        #100000;
        bad_count++;
        close_out();
    end
    initial begin
        rst         = 1'b1;
        reset_n     = 1'b0;
        pow2_req    = 1'b0;
        tx_data     = 8'h00;
        bad_count   = 0;
        checks_done = 0;
        repeat (16) @(negedge mclk);
        reset_n = 1'b1;
        rst     = 1'b0;
        repeat (8) @(negedge mclk);
        t_reset();
        t_decode();
        t_idle();
        t_pow2();
        t_rewrite();
        close_out();
    end
endmodule : sfl_link_tb
